//--- shared/ascp_pkg.sv
// Purpose: shared constants and types for the serial conversion port
// Assumes: core clock at 25 MHz, serial clock from the host
// Notes:   command byte fields follow the order in which bits arrive
package ascp_pkg;

    // ************************************************************
    // clocking and timing
    // ************************************************************
    localparam int CORE_HZ   = 25_000_000;
    localparam int FAST_HZ   = 1_500_000;   // internal clock, mid level
    localparam int SLOW_HZ   = 225_000;     // internal clock, high level
    localparam logic [6:0] FAST_DIV = 7'(CORE_HZ / FAST_HZ);
    localparam logic [6:0] SLOW_DIV = 7'(CORE_HZ / SLOW_HZ);
    localparam logic [3:0] CONV_STEPS = 4'hD;  // internal clock periods per conversion

    // ************************************************************
    // serial frame positions, counted in rising edges from the start bit
    // ************************************************************
    localparam logic [4:0] CNT_TRACK  = 5'h05;  // tracking begins after this bit
    localparam logic [4:0] CNT_CMD    = 5'h08;  // last command bit
    localparam logic [4:0] CNT_MSB    = 5'h09;  // falling edge after it shows the msb
    localparam logic [4:0] CNT_LSB    = 5'h14;  // falling edge after it shows the lsb
    localparam logic [4:0] CNT_MAX    = 5'h1F;

    // ************************************************************
    // encodings
    // ************************************************************
    localparam logic [1:0] LVL_LOW   = 2'h0;   // pin pulled low: power down
    localparam logic [1:0] LVL_MID   = 2'h1;   // pin left open
    localparam logic [1:0] LVL_HIGH  = 2'h2;   // pin pulled high
    localparam logic [1:0] PM_INT    = 2'h2;   // power mode bits for internal clock
    localparam logic [11:0] RESULT_RST = 12'h000;

    // command byte, first received bit on top
    typedef struct packed {
        logic       start;
        logic [2:0] channel_pick;
        logic       polarity_select;
        logic       input_pairing_select;
        logic [1:0] power_mode;
    } ascp_cmd_t;

    localparam ascp_cmd_t CMD_RST = 8'h00;

endpackage

//--- src/ascp_sync.sv
// Purpose: two-stage synchroniser for levels entering the core clock
// Assumes: the input is a slowly changing level
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module ascp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // level in and out
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ascp_sync_st_t;

    ascp_sync_st_t st;
    ascp_sync_st_t next_st;

    // shift the level through two stages
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

//--- src/ascp_port.sv
// Purpose: serial control and readout port of an 8-channel 12-bit converter
// Assumes: serial clock idle low, host samples result on rising edges
// Notes:   link logic runs on the serial clock and is cleared by chip select
// Summary of operation
// [RL1] low level on the three-level power pin powers down; other levels run
// [RL2] internal clock is 1.5MHz with pin open and 225kHz with pin high
// [RL3] command bits are captured on the rising serial clock edge
// [RL4] nothing is shifted in while chip select is high
// [RL5] result output changes on each falling serial clock edge
// [RL6] result output is driven only while chip select is low
// [RL7] internal mode: strobe low from conversion start until done
// [RL8] external mode: strobe high one serial period before msb decision
// [RL9] external mode: strobe driven only while chip select is low
// [RL10] host keeps serial clock duty cycle between 40% and 60%
// [RL11] internal mode: host waits for strobe rise before reading
// [RL12] leading zeros are skipped; first one is the command msb
// [RL13] command: start, channel, polarity, pairing, two power mode bits
// [RL14] track after fifth command bit, hold after eighth, on falling edges
// [RL15] external mode: host gives 15 serial clocks per conversion; host model gives 22 per frame after leading zeros
// [RL16] result shifts out msb first, one bit per serial period
// [RL17] chip select high abandons a partial command
`timescale 1ns/1ps
module ascp_port
    import ascp_pkg::*;
(
    // core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // serial link from the host
    input  wire logic        serial_clk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output      logic        dout,
    output      logic        dout_oe,
    output      logic        conversion_strobe,
    output      logic        conversion_strobe_oe,
    // three-level pin, as decoded by the pad
    input  wire logic [1:0]  three_level_power_input,
    // converter core
    input  wire logic [11:0] sar_result,
    output      logic        sample_track,
    output      ascp_cmd_t   command,
    output      logic        power_down,
    output      logic        conv_busy
);
    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [0:0] {C_IDLE, C_RUN} ascp_conv_t;

    typedef struct packed {
        logic       started;
        logic [4:0] cnt;
        ascp_cmd_t  shift;
        logic       cmd_done;
    } ascp_rise_t;

    typedef struct packed {
        logic track;
        logic strobe;
        logic dout;
    } ascp_fall_t;

    typedef struct packed {
        logic        done_prev;
        ascp_cmd_t   cmd;
        logic        ext_mode;
        ascp_conv_t  conv;
        logic [6:0]  div;
        logic [3:0]  step;
        logic        strobe;
        logic [11:0] result_word;
        logic        power_down;
    } ascp_core_t;

    ascp_rise_t rise;
    ascp_rise_t next_rise;
    ascp_fall_t fall;
    ascp_fall_t next_fall;
    ascp_core_t st;
    ascp_core_t next_st;

    logic       link_rst;
    logic       cs_idle;
    logic       done_s;
    logic [1:0] lvl_s;
    logic       ext_now;
    logic [6:0] div_lim;
    logic       ext_sel;

    // ************************************************************
    // crossings into the core domain
    // ************************************************************
    ascp_sync #(.W(1)) u_sync_cs (
        .clk (core_clk),
        .rst (rst),
        .d   (cs_n),
        .q   (cs_idle)
    );

    ascp_sync #(.W(1)) u_sync_done (
        .clk (core_clk),
        .rst (rst),
        .d   (rise.cmd_done),
        .q   (done_s)
    );

    ascp_sync #(.W(2)) u_sync_lvl (
        .clk (core_clk),
        .rst (rst),
        .d   (three_level_power_input),
        .q   (lvl_s)
    );

    // link logic is cleared by chip select and by power down
    assign link_rst = rst | cs_n | st.power_down; // RL4 RL17 RL1

    // ************************************************************
    // link, rising edge: command capture
    // ************************************************************
    always_comb begin
        next_rise = rise;
        if (!rise.started) begin
            if (din) begin // RL12
                next_rise.started = 1'b1;
                next_rise.cnt     = 5'h01;
                next_rise.shift   = ascp_cmd_t'({7'h00, din});
            end
        end else begin
            if (rise.cnt < CNT_CMD) begin
                next_rise.shift = ascp_cmd_t'({rise.shift[6:0], din}); // RL3 RL13
            end
            if (rise.cnt != CNT_MAX) begin
                next_rise.cnt = rise.cnt + 5'h01;
            end
            if (next_rise.cnt >= CNT_CMD) begin
                next_rise.cmd_done = 1'b1;
            end
        end
    end

    // rising edge register, held clear while chip select is high
    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            rise <= '0; // RL4 RL17
        end else begin
            rise <= next_rise;
        end
    end

    // ************************************************************
    // link, falling edge: track control, strobe and result bits
    // ************************************************************
    assign ext_now = rise.shift.power_mode != PM_INT;

    always_comb begin
        next_fall.track  = rise.started && rise.cnt >= CNT_TRACK
                           && rise.cnt < CNT_CMD; // RL14
        next_fall.strobe = rise.started && ext_now && rise.cnt == CNT_CMD; // RL8
        next_fall.dout   = 1'b0;
        if (rise.cnt >= CNT_MSB && rise.cnt <= CNT_LSB) begin
            next_fall.dout = st.result_word[4'(CNT_LSB - rise.cnt)]; // RL5 RL16
        end
    end

    // falling edge register
    always_ff @(negedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            fall <= '0;
        end else begin
            fall <= next_fall;
        end
    end

    // ************************************************************
    // core domain: mode, internal conversion, result holding
    // ************************************************************
    assign div_lim = (lvl_s == LVL_HIGH) ? SLOW_DIV : FAST_DIV; // RL2

    always_comb begin
        next_st            = st;
        next_st.done_prev  = done_s;
        next_st.power_down = lvl_s == LVL_LOW; // RL1
        // result word only moves while no frame can read it
        if (cs_idle && st.conv == C_IDLE) begin
            next_st.result_word = sar_result;
        end
        case (st.conv)
            C_IDLE: begin
                if (done_s && !st.done_prev && !st.power_down) begin
                    next_st.cmd      = rise.shift; // RL13
                    next_st.ext_mode = rise.shift.power_mode != PM_INT;
                    if (rise.shift.power_mode == PM_INT) begin
                        next_st.conv   = C_RUN;
                        next_st.strobe = 1'b0; // RL7
                        next_st.div    = 7'h00;
                        next_st.step   = 4'h0;
                    end
                end
            end
            C_RUN: begin
                if (st.div == div_lim - 7'h01) begin // RL2
                    next_st.div  = 7'h00;
                    next_st.step = st.step + 4'h1;
                    if (st.step == CONV_STEPS - 4'h1) begin
                        next_st.result_word = sar_result;
                        next_st.strobe      = 1'b1; // RL7
                        next_st.conv        = C_IDLE;
                    end
                end else begin
                    next_st.div = st.div + 7'h01;
                end
            end
            default: begin
                next_st.conv = C_IDLE;
            end
        endcase
        // power down abandons a conversion and restores the reset mode
        if (lvl_s == LVL_LOW) begin // RL1
            next_st.conv     = C_IDLE;
            next_st.strobe   = 1'b1;
            next_st.ext_mode = 1'b1;
        end
    end

    // core state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st             <= '0;
            st.cmd         <= CMD_RST;
            st.ext_mode    <= 1'b1;
            st.conv        <= C_IDLE;
            st.strobe      <= 1'b1;
            st.result_word <= RESULT_RST;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign dout                 = fall.dout;
    assign dout_oe              = !cs_n; // RL6
    // a complete command sets the mode at once; the core copy lags the crossing
    assign ext_sel              = rise.cmd_done ? ext_now : st.ext_mode;
    assign conversion_strobe    = ext_sel ? fall.strobe : st.strobe; // RL7 RL8
    assign conversion_strobe_oe = ext_sel ? !cs_n : 1'b1; // RL9
    assign sample_track         = fall.track;
    assign command              = st.cmd;
    assign power_down           = st.power_down;
    assign conv_busy            = st.conv == C_RUN;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_ext_pulse;
        fall.strobe ##1 !fall.strobe;
    endsequence

    AST_PD_STOPS: assert property (@(posedge core_clk) disable iff (rst) // RL1
        (lvl_s == LVL_LOW) |=> st.conv == C_IDLE && st.power_down)
        else $error("power down did not stop the port");

    AST_FAST_TICK: assert property (@(posedge core_clk) disable iff (rst) // RL2
        (st.conv == C_RUN && lvl_s == LVL_MID && $stable(lvl_s)
         && st.div == FAST_DIV - 7'h01) |=> st.div == 7'h00)
        else $error("fast internal clock period wrong");

    AST_INT_STROBE: assert property (@(posedge core_clk) disable iff (rst) // RL7
        $fell(st.strobe) |-> !st.strobe [*8])
        else $error("internal strobe rose too early");

    AST_DOUT_OE: assert property (@(posedge core_clk) disable iff (rst) // RL6
        cs_n |-> !dout_oe)
        else $error("result driven with chip select high");

    AST_STROBE_OE: assert property (@(posedge core_clk) disable iff (rst) // RL9
        (cs_n && st.ext_mode) |-> !conversion_strobe_oe)
        else $error("external strobe driven with chip select high");

    AST_SKIP_ZERO: assert property (@(posedge serial_clk) disable iff (link_rst) // RL12
        (!rise.started && !din) |=> !rise.started)
        else $error("leading zero taken as start");

    AST_START_BIT: assert property (@(posedge serial_clk) disable iff (link_rst) // RL12
        (!rise.started && din) |=> rise.started && rise.cnt == 5'h01 && rise.shift[0])
        else $error("start bit not taken");

    AST_CMD_SHIFT: assert property (@(posedge serial_clk) disable iff (link_rst) // RL3
        (rise.started && rise.cnt < CNT_CMD) |=> rise.shift[0] == $past(din))
        else $error("command bit not captured");

    AST_EXT_PULSE: assert property (@(negedge serial_clk) disable iff (link_rst) // RL8
        (rise.started && ext_now && rise.cnt == CNT_CMD) |=> s_ext_pulse)
        else $error("external strobe not one period");

    AST_TRACK_ON: assert property (@(negedge serial_clk) disable iff (link_rst) // RL14
        (rise.started && rise.cnt == CNT_TRACK) |=> fall.track)
        else $error("tracking did not start");

    AST_HOLD: assert property (@(negedge serial_clk) disable iff (link_rst) // RL14
        (rise.cnt == CNT_CMD) |=> !fall.track)
        else $error("hold did not start");

    AST_MSB_OUT: assert property (@(negedge serial_clk) disable iff (link_rst) // RL16
        (rise.cnt == CNT_MSB) |=> fall.dout == st.result_word[11])
        else $error("msb not shifted first");
endmodule

//--- verif/ascp_host.sv
// Purpose: serial host model driving clock, select and command bits
// Assumes: serial clock idle low, 15 ns period, also runs while deselected
// Notes:   result bits are sampled on rising edges; strobe is polled every 40 ns
`timescale 1ns/1ps
module ascp_host
    import ascp_pkg::*;
(
    // serial lines toward the port
    output logic      serial_clk,
    output logic      cs_n,
    output logic      din,
    // lines read back from the port
    input  wire logic dout,
    input  wire logic conversion_strobe
);
    // ************************************************************
    // host state and frame tasks
    // ************************************************************
    localparam realtime HALF = 7.5;
    int          rcount;
    int          wait_cycles;
    logic        saw_low;
    logic [11:0] got;

    initial begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        rcount = 0;
    end

    // one period: data set while low, result taken on the rise
    task automatic clk_bit(input logic b);
        din = b;
        #(HALF) serial_clk = 1'b1;
        if (rcount > 0 || b) rcount++;
        if (rcount >= 10 && rcount <= 21) got = {got[10:0], dout};
        #(HALF) serial_clk = 1'b0;
    endtask

    // clocks while deselected, data toggling
    task automatic idle_clocks(input int n);
        repeat (n) begin
            din = ~din;
            #(HALF) serial_clk = 1'b1;
            #(HALF) serial_clk = 1'b0;
        end
    endtask

    // whole or partial frame; internal mode waits for the strobe
    task automatic frame(input int zeros, input logic [7:0] cmd, input int nbits,
                         input logic int_mode);
        rcount = 0;
        got = 12'h000;
        wait_cycles = 0;
        saw_low = 1'b0;
        #(HALF) cs_n = 1'b0;
        #(HALF);
        repeat (zeros) clk_bit(1'b0);
        for (int i = 7; i > 7 - nbits; i--) clk_bit(cmd[i]);
        if (nbits == 8) begin
            if (int_mode) begin
                while (conversion_strobe !== 1'b0 && wait_cycles < 400) begin
                    #40 wait_cycles++;
                end
                saw_low = (conversion_strobe === 1'b0);
                wait_cycles = 0;
                // no rising edge before the strobe is back high
                while (conversion_strobe !== 1'b1 && wait_cycles < 3000) begin
                    #40 wait_cycles++;
                end
            end
            repeat (14) clk_bit(1'b0);
        end
        #(HALF) cs_n = 1'b1;
        din = ~din;
    endtask
endmodule

//--- verif/tb_top.sv
// Purpose: self-checking bench for the serial conversion port
// Assumes: core clock 40 ns, serial clock made by the host model
// Notes:   link outputs recorded at each serial falling edge
`timescale 1ns/1ps
module tb_top
    import ascp_pkg::*;
;
    // ************************************************************
    // signals, clock and instances
    // ************************************************************
    logic        core_clk = 1'b0;
    logic        rst;
    logic        serial_clk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        conversion_strobe;
    logic        conversion_strobe_oe;
    logic [1:0]  three_level_power_input;
    logic [11:0] sar_result;
    logic        sample_track;
    ascp_cmd_t   command;
    logic        power_down;
    logic        conv_busy;
    int          miscompares = 0;
    int          n_checks = 0;
    logic        trk [0:31];
    logic        stb [0:31];
    logic        oe  [0:31];
    logic        dat [0:31];

    always #20 core_clk = ~core_clk;

    ascp_port ascp_port_inst (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
        .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
        .conversion_strobe(conversion_strobe), .conversion_strobe_oe(conversion_strobe_oe),
        .three_level_power_input(three_level_power_input), .sar_result(sar_result),
        .sample_track(sample_track), .command(command), .power_down(power_down),
        .conv_busy(conv_busy));

    ascp_host ascp_host_inst (.serial_clk(serial_clk), .cs_n(cs_n), .din(din),
        .dout(dout), .conversion_strobe(conversion_strobe));

    // values seen by the host at rising edge k, read before the fall updates
    always @(negedge serial_clk) begin
        if (ascp_host_inst.rcount < 32) begin
            trk[ascp_host_inst.rcount] = sample_track;
            stb[ascp_host_inst.rcount] = conversion_strobe;
            oe[ascp_host_inst.rcount] = dout_oe;
            dat[ascp_host_inst.rcount] = dout;
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic run_frame(input int zeros, input ascp_cmd_t cmd, input logic int_mode,
                             input logic [11:0] value);
        sar_result = value;
        settle(4);
        ascp_host_inst.frame(zeros, cmd, 8, int_mode);
        settle(6);
        check(ascp_host_inst.got, value, "result word");
        check(command, cmd, "accepted command");
        check(dout_oe, 0, "result output released");
        check(conversion_strobe_oe, int_mode, "strobe release");
        for (int k = 1; k <= 22; k++) begin
            check(trk[k], 32'(k >= 6 && k <= 8), "track level");
            if (!int_mode) check(stb[k], 32'(k == 9), "ext strobe");
            check(oe[k], 1, "output enable in frame");
        end
        check(dat[22], 0, "result output after lsb");
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_ext_modes();
        for (int pm = 0; pm < 4; pm++) begin
            if (pm != 2) run_frame(pm, {1'b1, 3'(pm * 3), pm[0], pm[1], 2'(pm)}, 1'b0,
                                   12'(12'hA53 + pm * 12'h111));
        end
        $display("test ext_modes done");
    endtask

    task automatic t_abort();
        ascp_cmd_t last;
        last = command;
        ascp_host_inst.idle_clocks(6);
        ascp_host_inst.frame(0, 8'hC6, 4, 1'b0);
        settle(6);
        check(command, last, "partial command ignored");
        ascp_host_inst.idle_clocks(5);
        run_frame(0, 8'h9D, 1'b0, 12'h3C6);
        $display("test abort done");
    endtask

    task automatic t_int(input logic [1:0] level, input logic [6:0] div);
        int exp;
        exp = int'(CONV_STEPS) * int'(div);
        three_level_power_input = level;
        settle(5);
        run_frame(1, 8'hAE, 1'b1, 12'h96F);
        check(ascp_host_inst.saw_low, 1, "strobe low at start");
        check(32'(ascp_host_inst.wait_cycles >= exp - 6
                  && ascp_host_inst.wait_cycles <= exp + 6), 1, "conversion length");
        check(conv_busy, 0, "conversion finished");
        $display("test int_mode done");
    endtask

    task automatic t_power_down();
        three_level_power_input = LVL_LOW;
        settle(5);
        check(power_down, 1, "power down entered");
        three_level_power_input = LVL_MID;
        settle(5);
        check(power_down, 0, "power restored");
        run_frame(0, 8'hF1, 1'b0, 12'h5AA);
        $display("test power_down done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        rst = 1'b1;
        three_level_power_input = LVL_MID;
        sar_result = 12'h000;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        settle(4);
        t_ext_modes();
        t_abort();
        t_int(LVL_MID, FAST_DIV);
        t_int(LVL_HIGH, SLOW_DIV);
        t_power_down();
        close_out();
    end

    initial begin
        #500_000;
        miscompares++;
        close_out();
    end
endmodule
